//--- core/sits_top.sv
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module sits_top
   import sits_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   // AHB-Lite slave.
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   // Shift engine side.
   input  wire sits_flags_t           flags,
   input  wire logic                  linkClk,
   // Interrupt and select lines.
   output logic                       irq,
   output logic [SEL_COUNT-1:0]       selN
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------

   // Word index of an address, all ones when outside the block.
   function automatic logic [3:0] wordIdx(input logic [31:0] a);
      wordIdx = (a[31:6] == 26'h0) ? a[5:2] : 4'hF;
   endfunction

   // Interrupt causes gated by their enables.
   function automatic logic irqCalc(input logic [10:0] st,
                                    input logic [10:0] ct);
      irqCalc = |(st & ct & CTRL_DEFINED);
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   sits_bus_t               busState_q;
   sits_addr_t              addr_q;
   logic                    hreadyout_q;
   logic [31:0]             hrdata_q;
   logic [10:0]             ctrl_q;
   logic [SEL_COUNT-1:0]    mask_q;
   logic                    rxOverrun_q;
   logic                    txOverrun_q;
   logic                    irq_q;
   logic [SEL_COUNT-1:0]    selN_q;
   logic [LINKCNT_W-1:0]    linkCnt_q;
   logic                    linkLevel;
   logic                    linkRise;
   logic                    takeAddr;
   logic                    commit;
   logic                    wrCommit;
   logic                    rdCommit;
   logic                    anyFault;
   logic [10:0]             statusVal;
   logic [31:0]             readVal;

   // ---------------------------------------------------------------
   // Link clock crossing
   // ---------------------------------------------------------------

   // The serial clock is sampled by the system clock; its rises are
   // counted while a target is selected, as a progress indicator.
   sits_sync_rise u_linkSync (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .ce       (ce),
      .asyncIn  (linkClk),
      .levelOut (linkLevel),
      .riseOut  (linkRise)
   );

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------

   // An address phase is taken when the bus is ready; every non-sequential transfer
   // gets one wait state so that a write lands before any next read.
   assign takeAddr = hsel & (htrans == HTRANS_NSEQ) & hready;
   assign commit   = (busState_q == BUS_DATA);
   assign wrCommit = commit & addr_q.write & addr_q.mapped;
   assign rdCommit = commit & ~addr_q.write;

   // Bus phase sequencing.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busState_q  <= BUS_IDLE;
         hreadyout_q <= 1'b1;
         addr_q      <= '0;
      end else if (ce) begin
         case (busState_q)
            BUS_IDLE: begin
               if (takeAddr) begin
                  busState_q    <= BUS_DATA;
                  hreadyout_q   <= 1'b0;
                  addr_q.idx    <= wordIdx(haddr);
                  addr_q.mapped <= (wordIdx(haddr) == IDX_STATUS)
                                 | (wordIdx(haddr) == IDX_CONTROL)
                                 | (wordIdx(haddr) == IDX_MASK)
                                 | (wordIdx(haddr) == IDX_LINKCNT);
                  addr_q.write  <= hwrite;
               end
            end
            BUS_DATA: begin
               busState_q  <= BUS_IDLE;
               hreadyout_q <= 1'b1;
            end
            default: begin
               busState_q  <= BUS_IDLE;
               hreadyout_q <= 1'b1;
            end
         endcase
      end
   end

   // Status view: sticky overruns, live ready flags, derived fault.
   assign anyFault  = rxOverrun_q | txOverrun_q;
   always_comb begin
      statusVal                 = 11'h000;
      statusVal[BIT_RX_OVERRUN] = rxOverrun_q;
      statusVal[BIT_TX_OVERRUN] = txOverrun_q;
      statusVal[BIT_TX_EMPTY]   = ~flags.shiftBusy;
      statusVal[BIT_TX_FREE]    = flags.txHoldFree;
      statusVal[BIT_RX_FULL]    = flags.rxHoldFull;
      statusVal[BIT_ANY_FAULT]  = anyFault;
   end

   // Read multiplexer; unmapped words read as zero.
   always_comb begin
      case (addr_q.idx)
         IDX_STATUS:  readVal = {21'h0, statusVal};
         IDX_CONTROL: readVal = {21'h0, ctrl_q};
         IDX_MASK:    readVal = {{(32-SEL_COUNT){1'b0}}, mask_q};
         IDX_LINKCNT: readVal = {{(32-LINKCNT_W){1'b0}}, linkCnt_q};
         default:     readVal = 32'h0000_0000;
      endcase
   end

   // Read data is latched at the end of the wait state.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_q <= 32'h0000_0000;
      end else if (ce && rdCommit) begin
         hrdata_q <= readVal;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------

   // Control keeps only its defined bits; reads never touch it.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (ce && wrCommit && addr_q.idx == IDX_CONTROL) begin
         ctrl_q <= hwdata[10:0] & CTRL_DEFINED;
      end
   end

   // Target mask, one bit per select line, target 0 by default.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= MASK_RESET;
      end else if (ce && wrCommit && addr_q.idx == IDX_MASK) begin
         mask_q <= hwdata[SEL_COUNT-1:0];
      end
   end

   // Overrun flags: a status write clears them, but an event in the
   // same cycle wins so that no overrun is ever lost.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rxOverrun_q <= 1'b0;
         txOverrun_q <= 1'b0;
      end else if (ce) begin
         if (wrCommit && addr_q.idx == IDX_STATUS) begin
            rxOverrun_q <= flags.rxOverrunEvt;
            txOverrun_q <= flags.txOverrunEvt;
         end else begin
            rxOverrun_q <= rxOverrun_q | flags.rxOverrunEvt;
            txOverrun_q <= txOverrun_q | flags.txOverrunEvt;
         end
      end
   end

   // Serial clock rise counter; any write to it clears it.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         linkCnt_q <= '0;
      end else if (ce) begin
         if (wrCommit && addr_q.idx == IDX_LINKCNT) begin
            linkCnt_q <= '0;
         end else if (linkRise && linkLevel && !(&selN_q)) begin
            linkCnt_q <= linkCnt_q + 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Interrupt and selects
   // ---------------------------------------------------------------

   // One request from all enabled causes, fault included.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else if (ce) begin
         irq_q <= irqCalc(statusVal, ctrl_q);
      end
   end

   // Selects follow the mask while shifting or while forced; lines
   // are active low and rest high. Forcing lets one selection span
   // several words, so the mask is never gated by word boundaries.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         selN_q <= {SEL_COUNT{1'b1}};
      end else if (ce) begin
         if (ctrl_q[BIT_FORCE_SEL] || flags.shiftBusy) begin
            selN_q <= ~mask_q;
         end else begin
            selN_q <= {SEL_COUNT{1'b1}};
         end
      end
   end

   assign hreadyout = hreadyout_q;
   assign hresp     = HRESP_OKAY;
   assign hrdata    = hrdata_q;
   assign irq       = irq_q;
   assign selN      = selN_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------

   AST_RX_FULL_IRQ: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && ctrl_q[BIT_RX_FULL] && flags.rxHoldFull |=> irq_q)
      else $error("Receive-full interrupt missing.");

   AST_NO_ENABLE: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && ctrl_q == 11'h000 |=> !irq_q)
      else $error("Interrupt without any enable.");

   AST_TX_OVR_IRQ: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && ctrl_q[BIT_TX_OVERRUN] && txOverrun_q |=> irq_q)
      else $error("Transmit-overrun interrupt missing.");

   AST_RX_OVR_ONLY: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && ctrl_q == 11'h008 && !rxOverrun_q |=> !irq_q)
      else $error("Receive-overrun enable fired without flag.");

   AST_FAULT_OR: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && rdCommit && addr_q.idx == IDX_STATUS |=>
         hrdata_q[BIT_ANY_FAULT] ==
         (hrdata_q[BIT_RX_OVERRUN] | hrdata_q[BIT_TX_OVERRUN]))
      else $error("Fault bit differs from overrun OR.");

   AST_STATUS_CLEAR: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && wrCommit && addr_q.idx == IDX_STATUS
         && !flags.rxOverrunEvt && !flags.txOverrunEvt
      |=> !rxOverrun_q && !txOverrun_q)
      else $error("Status write left an overrun set.");

   AST_SET_WINS: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && flags.rxOverrunEvt |=> rxOverrun_q)
      else $error("Receive overrun event lost.");

   AST_CTRL_READ: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      rdCommit |=> $stable(ctrl_q))
      else $error("Control changed on a read.");

   AST_FORCED_SEL: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && ctrl_q[BIT_FORCE_SEL] |=> selN_q == ~$past(mask_q))
      else $error("Forced select not driven from mask.");

   AST_SEL_REST: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && !ctrl_q[BIT_FORCE_SEL] && !flags.shiftBusy
      |=> selN_q == {SEL_COUNT{1'b1}})
      else $error("Select active while idle.");

   AST_MASK_RESET: assert property (
      @(posedge clk_sys) $rose(rst_n) |-> mask_q == MASK_RESET
         && ctrl_q == CTRL_RESET)
      else $error("Reset values wrong.");

   AST_WAIT_ONE: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && takeAddr && busState_q == BUS_IDLE
      |=> !hreadyout_q ##1 hreadyout_q)
      else $error("Wait state length wrong.");

endmodule
`default_nettype wire

//--- shared/sits_pkg.sv
package sits_pkg;

   // ---------------------------------------------------------------
   // Register indices; byte address is four times the index.
   // ---------------------------------------------------------------
   localparam logic [3:0] IDX_STATUS  = 4'h2;
   localparam logic [3:0] IDX_CONTROL = 4'h3;
   localparam logic [3:0] IDX_MASK    = 4'h5;
   localparam logic [3:0] IDX_LINKCNT = 4'h6;

   // ---------------------------------------------------------------
   // Field positions shared by the status and control registers, except BIT_TX_EMPTY (status only) and BIT_FORCE_SEL (control only).
   // ---------------------------------------------------------------
   localparam int BIT_RX_OVERRUN = 3;
   localparam int BIT_TX_OVERRUN = 4;
   localparam int BIT_TX_EMPTY   = 5;
   localparam int BIT_TX_FREE    = 6;
   localparam int BIT_RX_FULL    = 7;
   localparam int BIT_ANY_FAULT  = 8;
   localparam int BIT_FORCE_SEL  = 10;

   // ---------------------------------------------------------------
   // Widths and reset values.
   // ---------------------------------------------------------------
   localparam int          SEL_COUNT    = 8;
   localparam int          LINKCNT_W    = 16;
   localparam logic [10:0] CTRL_RESET   = 11'h000;
   localparam logic [10:0] CTRL_DEFINED = 11'h5D8;
   localparam logic [7:0]  MASK_RESET   = 8'h01;
   localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
   localparam logic        HRESP_OKAY   = 1'h0;

   // ---------------------------------------------------------------
   // Types.
   // ---------------------------------------------------------------
   typedef struct packed {
      logic rxOverrunEvt;
      logic txOverrunEvt;
      logic txHoldFree;
      logic rxHoldFull;
      logic shiftBusy;
   } sits_flags_t;

   typedef struct packed {
      logic [3:0] idx;
      logic       mapped;
      logic       write;
   } sits_addr_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_DATA = 2'b10
   } sits_bus_t;

endpackage

//--- core/sits_sync_rise.sv
`timescale 1ns/1ns
`default_nettype none

module sits_sync_rise (
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic ce,
   // Asynchronous level in, synchronised level and rise out.
   input  wire logic asyncIn,
   output logic      levelOut,
   output logic      riseOut
);

   logic meta_q;
   logic sync_q;
   logic prev_q;

   // Two flops before use; only the second one reads the first.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else if (ce) begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edge detection looks only at settled flops.
   assign levelOut = sync_q;
   assign riseOut  = sync_q & ~prev_q;

endmodule
`default_nettype wire

//--- verification/sits_target_model.sv
`timescale 1ns/1ns
`default_nettype none

module sits_target_model
   import sits_pkg::*;
(
   // Select lines from the block, serial clock back to it.
   input  wire logic [SEL_COUNT-1:0] selN,
   output logic                      linkClk
);
   // These targets drive no data back, so several may be selected at
   // once without any contention on a shared input line.
   // The serial clock runs only inside a frame and rests low between
   // frames; the 3 ns offset keeps it out of phase with the system clock.
   initial begin
      linkClk = 1'b0;
      #3;
      forever begin
         #80;
         if (selN != {SEL_COUNT{1'b1}}) begin
            linkClk = ~linkClk;
         end else begin
            linkClk = 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench
   import sits_pkg::*;
;
   logic                 clk_sys, rst_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0]          haddr, hwdata, hrdata, rd, ctl, msk, st;
   logic [1:0]           htrans;
   sits_flags_t          flags;
   logic                 linkClk, irq, rxo, txo, ce;
   logic [SEL_COUNT-1:0] selN;
   int                   n_errors, compares, cycles, seed;

   // -----------------------------------------------------------------
   // Design, far-side targets and clock.
   // -----------------------------------------------------------------
   sits_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .flags(flags), .linkClk(linkClk),
      .irq(irq), .selN(selN));
   sits_target_model tgt (.selN(selN), .linkClk(linkClk));

   // Free-running system clock.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // -----------------------------------------------------------------
   // Tasks and expectation functions.
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (n_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // One single transfer; each phase is held until hready is seen high.
   task automatic bus(input logic wr, input logic [3:0] idx,
                      input logic [31:0] wd, output logic [31:0] rdat);
      hsel <= 1'b1;
      htrans <= HTRANS_NSEQ;
      haddr <= {26'h0, idx, 2'h0};
      hwrite <= wr;
      do begin
         @(posedge clk_sys);
      end while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge clk_sys);
      end while (hreadyout !== 1'b1);
      rdat = hrdata;
      check(hresp, HRESP_OKAY);
   endtask

   function automatic logic [31:0] exp_status(input logic ro, input logic to,
                                              input sits_flags_t f);
      logic [31:0] s;
      s = 32'h0;
      s[BIT_RX_OVERRUN] = ro;
      s[BIT_TX_OVERRUN] = to;
      s[BIT_TX_EMPTY] = ~f.shiftBusy;
      s[BIT_TX_FREE] = f.txHoldFree;
      s[BIT_RX_FULL] = f.rxHoldFull;
      s[BIT_ANY_FAULT] = ro | to;
      return s;
   endfunction

   function automatic logic exp_irq(input logic [31:0] s, input logic [31:0] c);
      return |(s[8:3] & c[8:3] & CTRL_DEFINED[8:3]);
   endfunction

   function automatic logic [7:0] exp_sel(input logic [31:0] c,
                                          input logic [31:0] m, input logic b);
      return (b | c[BIT_FORCE_SEL]) ? ~m[7:0] : 8'hFF;
   endfunction

   task automatic reset_checks();
      check(selN, 8'hFF);
      check(irq, 1'b0);
      bus(1'b0, IDX_CONTROL, 32'h0, rd);
      check(rd, {21'h0, CTRL_RESET});
      bus(1'b0, IDX_MASK, 32'h0, rd);
      check(rd, {24'h0, MASK_RESET});
   endtask

   // Hang guard: a run this long means a handshake never came back.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         end_of_test();
      end
   end

   // -----------------------------------------------------------------
   // Main sequence.
   // -----------------------------------------------------------------
   initial begin
      seed = 97;
      {n_errors, compares, cycles} = '0;
      {rst_n, hsel, hwrite, rxo, txo} = '0;
      ce = 1'b1;
      {haddr, hwdata} = '0;
      htrans = 2'h0;
      flags = '0;
      tick(16);
      rst_n <= 1'b1;
      tick(1);
      reset_checks();
      // Clock enable low freezes the selects; they follow once it rises.
      ce <= 1'b0;
      flags.shiftBusy <= 1'b1;
      tick(4);
      check(selN, 8'hFF);
      ce <= 1'b1;
      tick(2);
      check(selN, 8'hFE);
      flags.shiftBusy <= 1'b0;
      tick(2);
      // Receive-overrun enable alone: ready flags raise nothing.
      flags <= sits_flags_t'(5'h06);
      bus(1'b1, IDX_CONTROL, 32'h0000_0008, rd);
      tick(3);
      check(irq, 1'b0);
      flags.rxOverrunEvt <= 1'b1;
      tick(1);
      flags.rxOverrunEvt <= 1'b0;
      tick(2);
      check(irq, 1'b1);
      flags <= '0;
      bus(1'b1, IDX_STATUS, 32'h0, rd);
      tick(2);
      check(irq, 1'b0);
      // Unmapped index takes writes silently and reads zero.
      bus(1'b1, 4'h4, 32'hFFFFFFFF, rd);
      bus(1'b0, 4'h4, 32'h0, rd);
      check(rd, 32'h0);
      // Undefined control bits are dropped; repeated reads agree.
      bus(1'b1, IDX_CONTROL, 32'hFFFFFFFF, rd);
      bus(1'b0, IDX_CONTROL, 32'h0, rd);
      check(rd, {21'h0, CTRL_DEFINED});
      bus(1'b0, IDX_CONTROL, 32'h0, rd);
      check(rd, {21'h0, CTRL_DEFINED});
      // Forced select with several targets, held across several words.
      bus(1'b1, IDX_MASK, 32'h62, rd);
      bus(1'b1, IDX_CONTROL, 32'h400, rd);
      tick(2);
      check(selN, 8'h9D);
      bus(1'b1, IDX_CONTROL, 32'h418, rd);
      bus(1'b1, IDX_LINKCNT, 32'h0, rd);
      check(selN, 8'h9D);
      bus(1'b0, IDX_MASK, 32'h0, rd);
      check(rd, 32'h62);
      // Serial clock rises are counted only inside the forced frame.
      tick(250);
      bus(1'b0, IDX_LINKCNT, 32'h0, rd);
      check(rd >= 11 && rd <= 13, 1'b1);
      bus(1'b1, IDX_CONTROL, 32'h0, rd);
      tick(30);
      bus(1'b1, IDX_LINKCNT, 32'h0, rd);
      tick(60);
      bus(1'b0, IDX_LINKCNT, 32'h0, rd);
      check(rd, 32'h0);
      // Random control, mask and flags against the reference model.
      for (int i = 0; i < 40; i++) begin
         ctl = $random(seed);
         msk = $random(seed);
         st = $random(seed);
         bus(1'b1, IDX_CONTROL, ctl, rd);
         bus(1'b1, IDX_MASK, msk, rd);
         flags <= sits_flags_t'(st[4:0]);
         tick(1);
         flags.rxOverrunEvt <= 1'b0;
         flags.txOverrunEvt <= 1'b0;
         rxo = rxo | st[4];
         txo = txo | st[3];
         tick(2);
         check(selN, exp_sel(ctl, msk, st[0]));
         check(irq, exp_irq(exp_status(rxo, txo, flags), ctl));
         bus(1'b0, IDX_STATUS, 32'h0, rd);
         check(rd, exp_status(rxo, txo, flags));
         tick(1);
         check(irq, exp_irq(exp_status(rxo, txo, flags), ctl));
         if (st[8]) begin
            bus(1'b1, IDX_STATUS, st, rd);
            rxo = 1'b0;
            txo = 1'b0;
            tick(2);
            check(irq, exp_irq(exp_status(1'b0, 1'b0, flags), ctl));
         end
      end
      // Second reset in mid-run restores every default.
      flags <= '0;
      rst_n <= 1'b0;
      tick(2);
      rst_n <= 1'b1;
      tick(1);
      reset_checks();
      end_of_test();
   end
endmodule

`default_nettype wire
